// File: core/fsc_pkg.sv
package fsc_pkg;
  // Serial command opcodes, extended single-line protocol
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_BOOTCFG = 8'hB5;
  localparam logic [7:0] OP_WR_BOOTCFG = 8'hB1;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hD8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  // Status register field positions
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP0 = 2;
  localparam int SR_BP2 = 4;
  localparam int SR_TB = 5;
  localparam int SR_BP3 = 6;
  localparam int SR_SRWD = 7;
  // Boot configuration field positions
  localparam int CF_DUAL = 2;
  localparam int CF_QUAD = 3;
  localparam int CF_HOLD = 4;
  localparam int CF_DRV_LO = 6;
  localparam int CF_XIP_LO = 9;
  localparam int CF_DUMMY_LO = 12;
  // Values after reset
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] BOOTCFG_RST = 16'hFFFF;
  localparam logic [3:0] DUMMY_DEFAULT = 4'h8;
  localparam logic [3:0] DUMMY_ALT_DEFAULT = 4'hF;
  localparam logic [2:0] XIP_OFF = 3'b111;
  localparam logic [2:0] XIP_QUAD_IO = 3'b100;
  localparam logic [2:0] DRV_DEFAULT = 3'b111;
  localparam logic [2:0] DRV_RSVD_A = 3'b000;
  localparam logic [2:0] DRV_RSVD_B = 3'b100;
  localparam logic [1:0] PROTO_EXT = 2'b00;
  localparam logic [1:0] PROTO_DUAL = 2'b01;
  localparam logic [1:0] PROTO_QUAD = 2'b10;
  // Pin sync order: sclk, cs_n, mosi, wp_n
  localparam logic [3:0] SYNC_RST = 4'b1010;
  // Frame bit counts
  localparam logic [5:0] BITS_NONE = 6'h00;
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_HALF = 6'h10;
  localparam logic [5:0] BITS_ADDR = 6'h18;
  localparam logic [5:0] BITS_ADDR_DATA = 6'h20;
  localparam logic [5:0] BITS_MAX = 6'h3F;
  localparam logic [3:0] OPC_LAST = 4'h7;
  // Busy times
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REG_WRITE_TIME_NS = 5000;
  localparam int ARRAY_OP_TIME_NS = 20000;
  localparam logic [11:0] REG_WRITE_CYC = 12'((REG_WRITE_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [11:0] ARRAY_OP_CYC = 12'((ARRAY_OP_TIME_NS * 1000) / CLK_PERIOD_PS);
  // Frame engine states
  typedef enum logic [1:0] {ST_OPC, ST_ARG, ST_READ} fsc_state_t;
endpackage

// File: core/fsc_regs.sv
`timescale 1ns/100ps
// What this block does
// - Lock bit plus low protect pin refuses status writes
// - Only raising protect pin or reset releases the lock
// - Top/bottom bit anchors protected area
// - Nonzero block-protect bits block program/erase there
// - Bulk erase only when all protect bits zero
// - Clear write latch inhibits all modifying commands
// - Busy bit high during any write cycle
// - Volatile status bits clear on reset
// - Status read and written by dedicated commands
// - Dummy count from bits 15:12, 0/15 default
// - Bits 11:9 select power-on execute-in-place mode
// - Bits 8:6 hold driver strength, default 111
// - Bit 4 enables hold/reset function
// - Bit 3 low selects quad protocol
// - Bit 2 low selects dual protocol
// - Boot config ships all ones, own commands
// - Quad setting wins over dual setting
// - Working config loaded from boot config at reset
module fsc_regs
  import fsc_pkg::*;
(
  input wire logic ref_clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, acts as power cycle
  input wire logic spi_clk, // Serial clock from host
  input wire logic spi_cs_n, // Chip select, active low
  input wire logic spi_mosi, // Serial data in
  input wire logic wp_n, // Write-protect pin, active low
  output logic spi_miso, // Serial data out
  output logic spi_miso_oe, // High while driving serial out
  output logic wip, // Write cycle in progress
  output logic wel, // Write enable latch
  output logic [3:0] dummy_cycles, // Dummy clocks after fast reads
  output logic [2:0] execute_in_place_mode, // Mode entered after boot
  output logic [2:0] drive_strength, // Output driver code
  output logic hold_reset_en, // Hold/reset function enabled
  output logic [1:0] protocol // Extended, dual or quad
);

  // Pin synchronisers
  logic [3:0] sync1_r; // First stage, feeds only second
  logic [3:0] sync2_r; // Second stage
  logic [3:0] sync3_r; // Third stage
  logic [3:0] flt_r; // Accepted pin levels
  logic [3:0] flt_prev_r; // Levels one cycle earlier

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sync3_r <= SYNC_RST;
    end
    else
    begin
      sync1_r <= {wp_n, spi_mosi, spi_cs_n, spi_clk};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filt
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          flt_r[gi] <= SYNC_RST[gi];
        else if (sync2_r[gi] == sync3_r[gi])
          flt_r[gi] <= sync3_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flt_prev_r <= SYNC_RST;
    else
      flt_prev_r <= flt_r;
  end

  // Derived link events
  logic sclk_rise; // Serial clock rising
  logic sclk_fall; // Serial clock falling
  logic cs_active; // Frame open
  logic cs_rise; // Frame closed this cycle
  logic mosi_lvl; // Sampled data bit
  logic wp_high; // Protect pin released
  assign sclk_rise = flt_r[0] & ~flt_prev_r[0];
  assign sclk_fall = ~flt_r[0] & flt_prev_r[0];
  assign cs_active = ~flt_r[1];
  assign cs_rise = flt_r[1] & ~flt_prev_r[1];
  assign mosi_lvl = flt_r[2];
  assign wp_high = flt_r[3];

  // Register state
  logic [7:0] sr_nv_r; // Nonvolatile status bits, low two unused
  logic [15:0] cfg_nv_r; // Boot configuration
  logic wel_r; // Write enable latch
  logic busy_r; // Write cycle running
  logic [11:0] busy_cnt_r; // Cycles left in write cycle
  logic boot_r; // One-cycle load strobe after reset
  logic [7:0] status_byte; // Status as read back
  assign status_byte = {sr_nv_r[7:2], wel_r, busy_r};

  // Frame engine state
  fsc_state_t state_r; // Frame phase
  logic [3:0] bit_cnt_r; // Opcode bit count
  logic [7:0] opcode_r; // Received opcode
  logic [5:0] rx_cnt_r; // Bits after opcode, saturating
  logic [23:0] arg_r; // First three argument bytes
  logic [15:0] tx_r; // Readback rotator

  // Protected-area check; 64KB sectors in a 16MB window
  logic [3:0] bp_val; // Block-protect field
  logic [3:0] bp_shift; // Protected sector count exponent
  logic [8:0] prot_size; // Protected sector count
  logic [8:0] sector; // Addressed sector
  logic addr_prot; // Address falls in protected area
  assign bp_val = {sr_nv_r[SR_BP3], sr_nv_r[SR_BP2:SR_BP0]};
  assign bp_shift = bp_val - 4'h1;
  assign prot_size = 9'h001 << bp_shift;
  assign sector = {1'b0, arg_r[23:16]};

  always_comb
  begin
    if (bp_val == 4'h0)
      addr_prot = 1'b0;
    else if (bp_shift >= 4'h8)
      addr_prot = 1'b1; // Whole array covered
    else if (sr_nv_r[SR_TB])
      addr_prot = sector < prot_size; // Bottom anchored
    else
      addr_prot = sector >= (9'h100 - prot_size); // Top anchored
  end

  // Command decisions at frame close
  logic opc_done; // Full opcode seen
  logic wr_ok; // Latch set and idle
  logic hw_lock; // Hardware-protected state
  logic go_wren;
  logic go_wrdi;
  logic go_wrsr;
  logic go_wrcfg;
  logic go_prog;
  logic go_serase;
  logic go_berase;
  logic go_reg; // Register write cycle starts
  logic go_array; // Array cycle starts
  assign opc_done = cs_rise && (state_r != ST_OPC);
  assign wr_ok = wel_r && !busy_r;
  // Only the pin or a reset lifts the lock; status writes are refused meanwhile
  assign hw_lock = sr_nv_r[SR_SRWD] && !wp_high;
  assign go_wren = opc_done && opcode_r == OP_WR_ENABLE && rx_cnt_r == BITS_NONE && !busy_r;
  assign go_wrdi = opc_done && opcode_r == OP_WR_DISABLE && rx_cnt_r == BITS_NONE && !busy_r;
  assign go_wrsr = opc_done && opcode_r == OP_WR_STATUS && rx_cnt_r == BITS_BYTE
                   && wr_ok && !hw_lock;
  assign go_wrcfg = opc_done && opcode_r == OP_WR_BOOTCFG && rx_cnt_r == BITS_HALF
                    && wr_ok;
  assign go_prog = opc_done && opcode_r == OP_PROGRAM && rx_cnt_r >= BITS_ADDR_DATA
                   && wr_ok && !addr_prot;
  assign go_serase = opc_done && opcode_r == OP_SECT_ERASE && rx_cnt_r == BITS_ADDR
                     && wr_ok && !addr_prot;
  assign go_berase = opc_done && opcode_r == OP_BULK_ERASE && rx_cnt_r == BITS_NONE
                     && wr_ok && bp_val == 4'h0;
  assign go_reg = go_wrsr || go_wrcfg;
  assign go_array = go_prog || go_serase || go_berase;

  // Serial receive engine, mode 0: sample on rising edge
  always_ff @(posedge ref_clk)
  begin
    if (rst || !cs_active)
    begin
      state_r <= ST_OPC;
      bit_cnt_r <= 4'h0;
      rx_cnt_r <= BITS_NONE;
    end
    else if (sclk_rise)
    begin
      case (state_r)
        ST_OPC:
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == OPC_LAST)
          begin
            // Readback only for the two read commands
            if ({opcode_r[6:0], mosi_lvl} == OP_RD_STATUS
                || {opcode_r[6:0], mosi_lvl} == OP_RD_BOOTCFG)
              state_r <= ST_READ;
            else
              state_r <= ST_ARG;
          end
        end
        ST_ARG:
        begin
          if (rx_cnt_r != BITS_MAX)
            rx_cnt_r <= rx_cnt_r + 6'h01;
        end
        ST_READ:
          state_r <= ST_READ; // Host input ignored while reading
        default:
          state_r <= ST_OPC;
      endcase
    end
  end

  // Opcode and argument capture
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      opcode_r <= 8'h00;
      arg_r <= 24'h00_0000;
    end
    else if (sclk_rise && cs_active)
    begin
      if (state_r == ST_OPC)
        opcode_r <= {opcode_r[6:0], mosi_lvl};
      else if (state_r == ST_ARG && rx_cnt_r < BITS_ADDR)
        arg_r <= {arg_r[22:0], mosi_lvl}; // Extra data bytes dropped
    end
  end

  // Readback: bits change on falling edge, MSB first, repeating
  always_ff @(posedge ref_clk)
  begin
    if (rst || !cs_active)
    begin
      tx_r <= 16'h0000;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else if (sclk_rise && state_r == ST_OPC && bit_cnt_r == OPC_LAST)
    begin
      if ({opcode_r[6:0], mosi_lvl} == OP_RD_STATUS)
        tx_r <= {status_byte, status_byte};
      else
        tx_r <= {cfg_nv_r[7:0], cfg_nv_r[15:8]}; // Low byte first
    end
    else if (sclk_fall && state_r == ST_READ)
    begin
      spi_miso <= tx_r[15];
      spi_miso_oe <= 1'b1;
      tx_r <= {tx_r[14:0], tx_r[15]};
    end
  end

  // Nonvolatile status bits; reset stands for the factory state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sr_nv_r <= STATUS_RST;
    else if (go_wrsr)
      sr_nv_r <= {arg_r[7:2], 2'b00};
  end

  // Boot configuration, written low byte first
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_nv_r <= BOOTCFG_RST;
    else if (go_wrcfg)
      cfg_nv_r <= {arg_r[7:0], arg_r[15:8]};
  end

  // Write cycle timer; WIP spans the whole cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      busy_cnt_r <= 12'h000;
    end
    else if (go_reg)
    begin
      busy_r <= 1'b1;
      busy_cnt_r <= REG_WRITE_CYC - 12'h001;
    end
    else if (go_array)
    begin
      busy_r <= 1'b1;
      busy_cnt_r <= ARRAY_OP_CYC - 12'h001;
    end
    else if (busy_r)
    begin
      if (busy_cnt_r == 12'h000)
        busy_r <= 1'b0;
      else
        busy_cnt_r <= busy_cnt_r - 12'h001;
    end
  end

  // Write enable latch; completion clears it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wel_r <= 1'b0;
    else if (busy_r && busy_cnt_r == 12'h000)
      wel_r <= 1'b0;
    else if (go_wrdi)
      wel_r <= 1'b0;
    else if (go_wren)
      wel_r <= 1'b1;
  end

  // Status outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wip <= 1'b0;
      wel <= 1'b0;
    end
    else
    begin
      wip <= busy_r;
      wel <= wel_r;
    end
  end

  // Load strobe one cycle after reset release
  always_ff @(posedge ref_clk)
  begin
    boot_r <= rst;
  end

  // Working configuration; later writes never reach it, as reset restores all ones first
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dummy_cycles <= DUMMY_DEFAULT;
      execute_in_place_mode <= XIP_OFF;
      drive_strength <= DRV_DEFAULT;
      hold_reset_en <= 1'b1;
      protocol <= PROTO_EXT;
    end
    else if (boot_r)
    begin
      if (cfg_nv_r[15:12] == 4'h0 || cfg_nv_r[15:12] == DUMMY_ALT_DEFAULT)
        dummy_cycles <= DUMMY_DEFAULT;
      else
        dummy_cycles <= cfg_nv_r[15:12];
      // Reserved codes fall back to disabled
      if (cfg_nv_r[11:9] > XIP_QUAD_IO)
        execute_in_place_mode <= XIP_OFF;
      else
        execute_in_place_mode <= cfg_nv_r[11:9];
      if (cfg_nv_r[8:6] == DRV_RSVD_A || cfg_nv_r[8:6] == DRV_RSVD_B)
        drive_strength <= DRV_DEFAULT;
      else
        drive_strength <= cfg_nv_r[8:6];
      hold_reset_en <= cfg_nv_r[CF_HOLD];
      if (!cfg_nv_r[CF_QUAD])
        protocol <= PROTO_QUAD;
      else if (!cfg_nv_r[CF_DUAL])
        protocol <= PROTO_DUAL;
      else
        protocol <= PROTO_EXT;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  hw_lock_wr_a: assert property (hw_lock |=> $stable(sr_nv_r))
    else $error("status bits changed while hardware locked");
  latch_gate_a: assert property ($rose(busy_r) |-> $past(wel_r))
    else $error("write cycle started without latch");
  busy_start_a: assert property ((go_reg || go_array) |=> busy_r ##1 wip)
    else $error("busy not raised after accepted write");
  bulk_guard_a: assert property ((opc_done && opcode_r == OP_BULK_ERASE
    && bp_val != 4'h0) |=> !$rose(busy_r))
    else $error("bulk erase started with protect bits set");
  prot_block_a: assert property ((opc_done && addr_prot
    && (opcode_r == OP_PROGRAM || opcode_r == OP_SECT_ERASE)) |=> !$rose(busy_r))
    else $error("program or erase started in protected area");
  latch_clear_a: assert property ($fell(busy_r) |-> !wel_r)
    else $error("latch still set after write cycle");
  reset_clear_a: assert property ($fell(rst) |-> !wel_r && !busy_r)
    else $error("volatile bits not clear after reset");
  hold_load_a: assert property (boot_r |=> hold_reset_en == $past(cfg_nv_r[CF_HOLD]))
    else $error("hold enable not loaded at boot");
  quad_prio_a: assert property (boot_r && !cfg_nv_r[CF_QUAD] |=> protocol == PROTO_QUAD)
    else $error("quad setting did not win");
  busy_len_a: assert property (go_reg |=> busy_r [*8])
    else $error("register write cycle ended early");
endmodule

// File: test/fsc_host_model.sv
`timescale 1ns/100ps
module fsc_host_model (
  output logic spi_clk, // Serial clock, still and low outside frames
  output logic spi_cs_n, // Chip select, active low
  output logic spi_mosi, // Serial data to the device
  input wire logic spi_miso, // Serial data from the device
  input wire logic spi_miso_oe, // Device drives serial out
  output logic [15:0] rx_word, // Last word read back
  output logic rx_done // Short pulse when rx_word is fresh
);
  localparam realtime HALF = 62.5; // Half of the 125 ns link period
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx_word = 16'h0000;
    rx_done = 1'b0;
  end
  // Opcode, nout payload bits MSB first, then nin bits read back
  task automatic frame(input logic [7:0] opc, input int nout, input logic [31:0] dout,
                       input int nin);
    logic [39:0] sh;
    logic [15:0] rx;
    sh = {opc, dout << (32 - nout)};
    rx = 16'h0000;
    // Edges land on system clock edges, so every serial line change is non-blocking
    spi_cs_n <= 1'b0;
    #HALF;
    for (int i = 0; i < 8 + nout + nin; i++)
    begin
      // Past the payload the line is not ours to hold, so it keeps toggling
      spi_mosi <= (i < 8 + nout) ? sh[39 - i] : ~spi_mosi;
      #HALF spi_clk <= 1'b1;
      // Undriven serial out reads as unknown, so it can never pass a compare
      if (i >= 8 + nout)
        rx = {rx[14:0], (spi_miso_oe === 1'b1) ? spi_miso : 1'bx};
      #HALF spi_clk <= 1'b0;
    end
    #HALF spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    #(2 * HALF);
    if (nin > 0)
    begin
      rx_word = rx;
      rx_done = 1'b1;
      #1 rx_done = 1'b0;
    end
  endtask
endmodule

// File: test/flash_status_config_regs_tb.sv
`timescale 1ns/100ps
module flash_status_config_regs_tb
  import fsc_pkg::*;
;
  logic ref_clk = 1'b0; // 200 MHz system clock
  logic rst = 1'b1; // Synchronous reset
  logic wp_n = 1'b1; // Write-protect pin
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, wip, wel, hold_reset_en, rx_done;
  logic [3:0] dummy_cycles;
  logic [2:0] execute_in_place_mode, drive_strength;
  logic [1:0] protocol;
  logic [15:0] rx_word;
  logic [15:0] exp_q[$]; // Expected read words, oldest first
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h64fc_52cb;
  logic [7:0] d;
  logic [15:0] v;
  logic [15:0] port_word;
  // Working configuration plus both volatile flags, in one word
  assign port_word = {1'b0, dummy_cycles, execute_in_place_mode, drive_strength,
                      hold_reset_en, protocol, wip, wel};
  localparam logic [15:0] PORT_DEF = {1'b0, DUMMY_DEFAULT, XIP_OFF, DRV_DEFAULT, 1'b1,
                                      PROTO_EXT, 2'b00};
  always #2.5 ref_clk = ~ref_clk;
  fsc_regs u_dut (.ref_clk(ref_clk), .rst(rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .wp_n(wp_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .wip(wip), .wel(wel), .dummy_cycles(dummy_cycles),
    .execute_in_place_mode(execute_in_place_mode), .drive_strength(drive_strength),
    .hold_reset_en(hold_reset_en), .protocol(protocol));
  fsc_host_model u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_word(rx_word), .rx_done(rx_done));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Every read word is judged here, against the oldest note
  always @(posedge rx_done)
  begin
    if (exp_q.size() == 0)
    begin
      compares++;
      err_total++;
      $display("mismatch at %0t: unexpected read", $time);
    end
    else
      chk(rx_word, exp_q.pop_front(), "read word");
  end
  // Hang guard, well above the expected run length
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      chk(16'h0000, 16'h0001, "timeout");
      end_of_test();
    end
  end
  task automatic do_reset;
    @(posedge ref_clk) rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
  // Frames start on a clock edge so the host never drifts off the grid
  task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] dat);
    @(posedge ref_clk);
    u_host.frame(op, n, dat, 0);
  endtask
  task automatic rd_sr(input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    @(posedge ref_clk);
    u_host.frame(OP_RD_STATUS, 0, 32'h0000_0000, 8);
  endtask
  // Low byte travels first on the wire
  task automatic rd_cf(input logic [15:0] e);
    exp_q.push_back({e[7:0], e[15:8]});
    @(posedge ref_clk);
    u_host.frame(OP_RD_BOOTCFG, 0, 32'h0000_0000, 16);
  endtask
  // Bounded wait on the busy flag; the cap is above the longest array cycle
  task automatic wait_idle;
    int n;
    n = 0;
    while (wip !== 1'b0 && n < 6000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({15'h0000, wip}, 16'h0000, "busy never ended");
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wren;
    cmd(OP_WR_ENABLE, 0, 32'h0000_0000);
  endtask
  task automatic wr_sr(input logic [7:0] s);
    wren();
    cmd(OP_WR_STATUS, 8, {24'h00_0000, s});
    wait_idle();
  endtask
  logic [32:0] ptab[4] = '{{8'h04, 24'hFF_0000, 1'b0}, {8'h04, 24'h00_0000, 1'b1},
                           {8'h24, 24'h00_0000, 1'b0}, {8'h24, 24'hFF_0000, 1'b1}};
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk(port_word, PORT_DEF, "ports after reset");
    rd_sr(STATUS_RST);
    rd_cf(BOOTCFG_RST);
    // Status write with the latch clear must not start a cycle
    cmd(OP_WR_STATUS, 8, 32'h0000_009C);
    chk({15'h0000, wip}, 16'h0000, "write without latch");
    rd_sr(8'h00);
    // Random status write, read back mid-cycle and after
    seed = xs(seed);
    d = seed[7:0] & 8'h7C;
    wren();
    chk({15'h0000, wel}, 16'h0001, "latch set");
    cmd(OP_WR_STATUS, 8, {24'h00_0000, d});
    chk({15'h0000, wip}, 16'h0001, "busy during write");
    rd_sr(d | 8'h03);
    wait_idle();
    chk({15'h0000, wel}, 16'h0000, "latch after write");
    rd_sr(d);
    // Hardware lock: lock bit with pin low refuses, pin high releases
    wr_sr(8'h80);
    @(posedge ref_clk) wp_n <= 1'b0;
    wren();
    cmd(OP_WR_STATUS, 8, 32'h0000_0000);
    chk({15'h0000, wip}, 16'h0000, "locked write");
    rd_sr(8'h82);
    wren();
    cmd(OP_WR_STATUS, 8, 32'h0000_0000);
    rd_sr(8'h82);
    @(posedge ref_clk) wp_n <= 1'b1;
    cmd(OP_WR_STATUS, 8, 32'h0000_0000);
    wait_idle();
    rd_sr(8'h00);
    // Whole-array erase refused while the BP0 protect bit is set
    wr_sr(8'h04);
    wren();
    cmd(OP_BULK_ERASE, 0, 32'h0000_0000);
    chk({14'h0000, wip, wel}, 16'h0001, "erase when protected");
    cmd(OP_WR_STATUS, 8, 32'h0000_0000);
    wait_idle();
    wren();
    cmd(OP_BULK_ERASE, 0, 32'h0000_0000);
    chk({15'h0000, wip}, 16'h0001, "erase when open");
    wait_idle();
    chk({15'h0000, wel}, 16'h0000, "latch after erase");
    // Top and bottom anchoring of a one-sector protected area
    foreach (ptab[i])
    begin
      wr_sr(ptab[i][32:25]);
      wren();
      seed = xs(seed);
      cmd(OP_PROGRAM, 32, {ptab[i][24:1], seed[7:0]});
      chk({15'h0000, wip}, {15'h0000, ptab[i][0]}, "program guard");
      wait_idle();
      chk({15'h0000, wel}, {15'h0000, ~ptab[i][0]}, "latch after program");
    end
    // Sector erase: bottom sector still guarded, a far sector is open
    wren();
    cmd(OP_SECT_ERASE, 24, 32'h0000_0000);
    chk({15'h0000, wip}, 16'h0000, "erase in protected sector");
    cmd(OP_SECT_ERASE, 24, 32'h0080_0000);
    chk({15'h0000, wip}, 16'h0001, "erase in open sector");
    wait_idle();
    chk({15'h0000, wel}, 16'h0000, "latch after sector erase");
    // Write disable drops the latch again
    wren();
    cmd(OP_WR_DISABLE, 0, 32'h0000_0000);
    chk({15'h0000, wel}, 16'h0000, "latch after disable");
    // Boot configuration write never reaches the outputs; a reboot restores all ones
    seed = xs(seed);
    v = seed[15:0];
    wren();
    cmd(OP_WR_BOOTCFG, 16, {16'h0000, v[7:0], v[15:8]});
    chk({15'h0000, wip}, 16'h0001, "busy during config write");
    wait_idle();
    rd_cf(v);
    chk(port_word, PORT_DEF, "config held until boot");
    do_reset();
    chk(port_word, PORT_DEF, "ports after reboot");
    rd_cf(BOOTCFG_RST);
    rd_sr(STATUS_RST);
    repeat (50) @(posedge ref_clk);
    chk(16'(exp_q.size()), 16'h0000, "reads outstanding");
    end_of_test();
  end
endmodule
